/* verilog/eac_defines.vh */
// Register map, field positions and reset values of the access registers
`ifndef EAC_DEFINES_VH
`define EAC_DEFINES_VH
`define EAC_OFS_EEPROM_CTRL   12'h42C
`define EAC_OFS_EXP_CTRL      12'h430
`define EAC_OFS_IRQ_STATUS    12'h440
`define EAC_OFS_IRQ_MASK      12'h444
`define EAC_OFS_EXP_DIR       12'h448
`define EAC_EE_ADDR_LSB       0
`define EAC_EE_ADDR_MSB       15
`define EAC_EE_BYTE_LSB       16
`define EAC_EE_BYTE_MSB       23
`define EAC_EE_BUSY_BIT       24
`define EAC_EE_DONE_BIT       25
`define EAC_EE_OP_BIT         26
`define EAC_EX_PINS_LSB       0
`define EAC_EX_PINS_MSB       15
`define EAC_EX_REFRESH_BIT    24
`define EAC_EX_TEST_BIT       25
`define EAC_EX_SEL_LSB        26
`define EAC_EX_SEL_MSB        29
`define EAC_EX_DONE_BIT       31
`define EAC_EX_COUNT          11
`define EAC_EX_SEL_MAX        4'hA
`define EAC_OP_WRITE          1'h0
`define EAC_OP_READ           1'h1
`define EAC_IRQ_EE_BIT        0
`define EAC_IRQ_EX_BIT        1
`define EAC_RESET_WORD        32'h00000000
`endif

/* verilog/eac_access_regs.v */
// EEPROM and I/O expander access register bank on Avalon-MM
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "eac_defines.vh"
module eac_access_regs (
  input  wire         clk,
  input  wire         rst,
  input  wire [11:0]  avs_address,
  input  wire         avs_read,
  input  wire         avs_write,
  input  wire [31:0]  avs_writedata,
  input  wire [3:0]   avs_byteenable,
  output reg  [31:0]  avs_readdata,
  output wire         avs_waitrequest,
  output reg          ee_start,
  output reg          ee_op,
  output reg  [15:0]  ee_addr,
  output reg  [7:0]   ee_wdata,
  input  wire         ee_done,
  input  wire [7:0]   ee_rdata,
  output reg          ex_start,
  output reg  [3:0]   ex_index,
  output reg  [15:0]  ex_out_value,
  output reg          ex_test_mode,
  input  wire         ex_done,
  input  wire [15:0]  ex_in_value,
  input  wire [15:0]  core_out_value,
  output wire         irq
);
  // ==========================================================
  // Storage
  reg  [15:0] ee_addr_r;
  reg  [7:0]  ee_byte_r;
  reg         ee_busy_r;
  reg         ee_done_r;
  reg         ee_op_r;
  reg         ee_op_run_r;
  reg  [3:0]  ex_sel_r;
  reg         ex_test_r;
  reg         ex_done_r;
  reg         ex_busy_r;
  reg  [3:0]  ex_run_r;
  reg  [15:0] ex_dir_r [0:`EAC_EX_COUNT-1];
  reg  [15:0] ex_mir_r [0:`EAC_EX_COUNT-1];
  reg  [15:0] ex_tval_r [0:`EAC_EX_COUNT-1];
  reg  [1:0]  irq_mask_r;
  reg         ack_r;
  wire        sel_ok;
  wire        wr_ok;
  wire        rd_ok;
  wire [31:0] wmask;
  wire [31:0] wd;
  wire        wr_ee;
  wire        wr_ex;
  wire        wr_irq_st;
  wire        wr_irq_mk;
  wire        wr_dir;
  wire        ee_launch;
  wire        ex_refresh;
  wire        ex_test_wr;
  wire [15:0] sel_dir;
  wire [15:0] sel_mir;
  reg  [15:0] ee_addr_nxt;
  reg         ee_op_nxt;
  reg  [3:0]  ex_sel_nxt;
  reg         ex_test_nxt;
  reg         ex_sel_bad;
  reg  [31:0] rd_ee_word;
  reg  [31:0] rd_ex_word;
  reg  [31:0] rd_st_word;
  reg  [31:0] rd_mk_word;
  reg  [31:0] rd_dir_word;
  reg  [31:0] rd_word;
  wire [1:0]  irq_status;
  wire [1:0]  irq_pending;
  wire        ee_finish;
  wire        ex_finish;
  wire        ee_clear;
  wire        ex_clear;
  wire [15:0] run_tval;
  wire        run_ok;
  genvar      g;

  // ==========================================================
  // Avalon slave: one wait cycle, answer on second cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign wr_ok = avs_write & ack_r;
  assign rd_ok = avs_read & ~ack_r;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wd = avs_writedata & wmask;
  assign wr_ee = wr_ok & (avs_address == `EAC_OFS_EEPROM_CTRL);
  assign wr_ex = wr_ok & (avs_address == `EAC_OFS_EXP_CTRL);
  assign wr_irq_st = wr_ok & (avs_address == `EAC_OFS_IRQ_STATUS);
  assign wr_irq_mk = wr_ok & (avs_address == `EAC_OFS_IRQ_MASK);
  assign wr_dir = wr_ok & (avs_address == `EAC_OFS_EXP_DIR);
  assign sel_ok = (ex_sel_r <= `EAC_EX_SEL_MAX);
  assign sel_dir = sel_ok ? ex_dir_r[ex_sel_r] : 16'h0000;
  assign sel_mir = sel_ok ? ex_mir_r[ex_sel_r] : 16'h0000;

  always @(posedge clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  // ==========================================================
  // EEPROM access
  // Launch, finish and clear conditions
  assign ee_finish = ee_busy_r & ee_done;
  assign ee_clear = (wr_ee & avs_byteenable[3] & wd[`EAC_EE_DONE_BIT]) |
                    (wr_irq_st & wd[`EAC_IRQ_EE_BIT]);

  // Next address and operation, taken from the word being written
  always @* begin
    ee_addr_nxt = ee_addr_r;
    ee_op_nxt = ee_op_r;
    if (wr_ee & avs_byteenable[0]) begin
      ee_addr_nxt[7:0] = wd[7:0];
    end
    if (wr_ee & avs_byteenable[1]) begin
      ee_addr_nxt[15:8] = wd[15:8];
    end
    if (wr_ee & avs_byteenable[3]) begin
      ee_op_nxt = wd[`EAC_EE_OP_BIT];
    end
  end

  assign ee_launch = wr_ee & avs_byteenable[2];
  always @(posedge clk) begin
    if (rst) begin
      ee_addr_r <= 16'h0000;
      ee_byte_r <= 8'h00;
      ee_busy_r <= 1'b0;
      ee_done_r <= 1'b0;
      ee_op_r <= 1'b0;
      ee_op_run_r <= 1'b0;
      ee_start <= 1'b0;
      ee_op <= 1'b0;
      ee_addr <= 16'h0000;
      ee_wdata <= 8'h00;
    end else begin
      ee_start <= 1'b0;
      ee_addr_r <= ee_addr_nxt;
      ee_op_r <= ee_op_nxt;
      if (ee_launch & ~ee_busy_r) begin
        ee_start <= 1'b1;
        ee_busy_r <= 1'b1;
        ee_op_run_r <= ee_op_nxt;
        ee_op <= ee_op_nxt;
        ee_addr <= ee_addr_nxt;
        ee_wdata <= wd[`EAC_EE_BYTE_MSB:`EAC_EE_BYTE_LSB];
        if (ee_op_nxt == `EAC_OP_WRITE)
          ee_byte_r <= wd[`EAC_EE_BYTE_MSB:`EAC_EE_BYTE_LSB];
      end else if (ee_busy_r & ee_done) begin
        ee_busy_r <= 1'b0;
        if (ee_op_run_r == `EAC_OP_READ)
          ee_byte_r <= ee_rdata;
      end
      if (ee_finish)
        ee_done_r <= 1'b1;
      else if (ee_clear)
        ee_done_r <= 1'b0;
    end
  end

  // ==========================================================
  // Expander access
  assign ex_refresh = wr_ex & avs_byteenable[3] & wd[`EAC_EX_REFRESH_BIT]
                      & ~ex_sel_bad;
  assign ex_test_wr = wr_ex & ex_test_r & ~ex_sel_bad &
                      (avs_byteenable[1] | avs_byteenable[0]);
  assign ex_finish = ex_busy_r & ex_done;
  assign ex_clear = (wr_ex & avs_byteenable[3] & wd[`EAC_EX_DONE_BIT]) |
                    (wr_irq_st & wd[`EAC_IRQ_EX_BIT]);

  // Next select and test mode; reserved select codes are dropped
  always @* begin
    ex_sel_nxt = ex_sel_r;
    ex_test_nxt = ex_test_r;
    ex_sel_bad = 1'b0;
    if (wr_ex & avs_byteenable[3]) begin
      ex_test_nxt = wd[`EAC_EX_TEST_BIT];
      if (wd[`EAC_EX_SEL_MSB:`EAC_EX_SEL_LSB] <= `EAC_EX_SEL_MAX) begin
        ex_sel_nxt = wd[`EAC_EX_SEL_MSB:`EAC_EX_SEL_LSB];
      end else begin
        ex_sel_bad = 1'b1;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ex_sel_r <= 4'h0;
      ex_test_r <= 1'b0;
      ex_done_r <= 1'b0;
      ex_busy_r <= 1'b0;
      ex_run_r <= 4'h0;
      ex_start <= 1'b0;
      ex_index <= 4'h0;
      irq_mask_r <= 2'h0;
    end else begin
      ex_start <= 1'b0;
      ex_sel_r <= ex_sel_nxt;
      ex_test_r <= ex_test_nxt;
      if (wr_irq_mk & avs_byteenable[0])
        irq_mask_r <= wd[1:0];
      if ((ex_refresh | ex_test_wr) & ~ex_busy_r) begin
        ex_start <= 1'b1;
        ex_busy_r <= 1'b1;
        ex_run_r <= ex_sel_nxt;
        ex_index <= ex_sel_nxt;
      end else if (ex_busy_r & ex_done) begin
        ex_busy_r <= 1'b0;
      end
      if (ex_finish)
        ex_done_r <= 1'b1;
      else if (ex_clear)
        ex_done_r <= 1'b0;
    end
  end

  // Per-expander direction, test values and mirrors
  generate
    for (g = 0; g < `EAC_EX_COUNT; g = g + 1) begin : gen_exp
      // Direction of each pin, one means output
      always @(posedge clk) begin
        if (rst) begin
          ex_dir_r[g] <= 16'h0000;
        end else if (wr_dir & (ex_sel_r == g) & sel_ok) begin
          ex_dir_r[g] <= wd[15:0];
        end
      end

      // Test values, only output bits take the write
      always @(posedge clk) begin
        if (rst) begin
          ex_tval_r[g] <= 16'h0000;
        end else if (ex_test_wr & (ex_sel_nxt == g)) begin
          ex_tval_r[g] <= (ex_tval_r[g] & ~ex_dir_r[g]) |
                          (wd[15:0] & ex_dir_r[g]);
        end
      end

      // Mirror: inputs as fetched, outputs as sent
      always @(posedge clk) begin
        if (rst) begin
          ex_mir_r[g] <= 16'h0000;
        end else if (ex_finish & (ex_run_r == g)) begin
          ex_mir_r[g] <= (ex_in_value & ~ex_dir_r[g]) |
                         (ex_out_value & ex_dir_r[g]);
        end
      end
    end
  endgenerate

  // Values sent to the expander being served
  assign run_ok = (ex_run_r <= `EAC_EX_SEL_MAX);
  assign run_tval = run_ok ? ex_tval_r[ex_run_r] : 16'h0000;

  always @(posedge clk) begin
    if (rst) begin
      ex_test_mode <= 1'b0;
    end else begin
      ex_test_mode <= ex_test_r;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      ex_out_value <= 16'h0000;
    end else if (ex_test_r & run_ok) begin
      ex_out_value <= run_tval;
    end else begin
      ex_out_value <= core_out_value;
    end
  end

  // ==========================================================
  // Interrupt and read data
  // Status doubles as the done flags; level output while any is unmasked
  assign irq_status = {ex_done_r, ee_done_r};
  assign irq_pending = irq_status & irq_mask_r;
  assign irq = |irq_pending;

  // Field layout of the EEPROM word
  always @* begin
    rd_ee_word = 32'h00000000;
    rd_ee_word[`EAC_EE_ADDR_MSB:`EAC_EE_ADDR_LSB] = ee_addr_r;
    rd_ee_word[`EAC_EE_BYTE_MSB:`EAC_EE_BYTE_LSB] = ee_byte_r;
    rd_ee_word[`EAC_EE_BUSY_BIT] = ee_busy_r;
    rd_ee_word[`EAC_EE_DONE_BIT] = ee_done_r;
    rd_ee_word[`EAC_EE_OP_BIT] = ee_op_r;
  end

  // Field layout of the expander word; refresh never reads back
  always @* begin
    rd_ex_word = 32'h00000000;
    rd_ex_word[`EAC_EX_PINS_MSB:`EAC_EX_PINS_LSB] = sel_mir;
    rd_ex_word[`EAC_EX_REFRESH_BIT] = 1'b0;
    rd_ex_word[`EAC_EX_TEST_BIT] = ex_test_r;
    rd_ex_word[`EAC_EX_SEL_MSB:`EAC_EX_SEL_LSB] = ex_sel_r;
    rd_ex_word[`EAC_EX_DONE_BIT] = ex_done_r;
  end

  always @* begin
    rd_st_word = 32'h00000000;
    rd_st_word[`EAC_IRQ_EE_BIT] = irq_status[0];
    rd_st_word[`EAC_IRQ_EX_BIT] = irq_status[1];
  end

  always @* begin
    rd_mk_word = 32'h00000000;
    rd_mk_word[1:0] = irq_mask_r;
  end

  always @* begin
    rd_dir_word = 32'h00000000;
    rd_dir_word[15:0] = sel_dir;
  end

  // Word selected by the bus address
  always @* begin
    case (avs_address)
      `EAC_OFS_EEPROM_CTRL: begin
        rd_word = rd_ee_word;
      end
      `EAC_OFS_EXP_CTRL: begin
        rd_word = rd_ex_word;
      end
      `EAC_OFS_IRQ_STATUS: begin
        rd_word = rd_st_word;
      end
      `EAC_OFS_IRQ_MASK: begin
        rd_word = rd_mk_word;
      end
      `EAC_OFS_EXP_DIR: begin
        rd_word = rd_dir_word;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Read data registered in the wait cycle, valid with the answer
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= `EAC_RESET_WORD;
    end else if (rd_ok) begin
      avs_readdata <= rd_word;
    end
  end
endmodule // eac_access_regs
`default_nettype wire

/* test/eac_access_regs_props.sv */
// Concurrent checks on the access register ports
`timescale 1ns/1ps
`default_nettype none
`include "eac_defines.vh"
module eac_access_regs_props (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        ee_start,
  input wire logic        ee_op,
  input wire logic [15:0] ee_addr,
  input wire logic [7:0]  ee_wdata,
  input wire logic        ex_start,
  input wire logic [3:0]  ex_index,
  input wire logic [15:0] ex_out_value,
  input wire logic        ex_test_mode,
  input wire logic [15:0] core_out_value,
  input wire logic        ee_done,
  input wire logic        ex_done,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Checks
  sequence s_ee_wr;
    avs_write && !avs_waitrequest && avs_address == `EAC_OFS_EEPROM_CTRL;
  endsequence
  sequence s_ex_wr;
    avs_write && !avs_waitrequest && avs_address == `EAC_OFS_EXP_CTRL;
  endsequence
  AST_WAIT: assert property (
    $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("write wait not one cycle");
  AST_LAUNCH: assert property (
    ee_start |-> $past(avs_write && !avs_waitrequest
      && avs_address == `EAC_OFS_EEPROM_CTRL))
    else $error("launch without byte write");
  AST_OP: assert property (
    s_ee_wr ##1 ee_start |-> ee_op == $past(avs_writedata[26]))
    else $error("wrong operation");
  AST_ADDR: assert property (
    s_ee_wr ##1 ee_start |-> ee_addr == $past(avs_writedata[15:0])
      && (ee_op || ee_wdata == $past(avs_writedata[23:16])))
    else $error("wrong address or byte");
  AST_EXSTART: assert property (
    s_ex_wr ##0 avs_byteenable[3] && avs_writedata[24]
      && avs_writedata[29:26] <= `EAC_EX_SEL_MAX
      |=> ex_start && ex_index == $past(avs_writedata[29:26]))
    else $error("refresh not launched");
  AST_TESTOUT: assert property (
    ex_test_mode [*3] ##0 !avs_write && !$past(avs_write)
      |=> $stable(ex_out_value))
    else $error("output moved in test mode");
  AST_COREOUT: assert property (
    !ex_test_mode && !$past(rst) |-> ex_out_value == $past(core_out_value))
    else $error("core value not sent");
  AST_IRQ: assert property (
    $rose(irq) |-> $past((avs_write && !avs_waitrequest) || ee_done
      || ex_done))
    else $error("irq rose without cause");
  AST_REFRESH_RD: assert property (
    avs_read && !avs_waitrequest && avs_address == `EAC_OFS_EXP_CTRL
      |-> !avs_readdata[24])
    else $error("refresh bit read as one");
  AST_EX_IDX: assert property (
    ex_start |-> ex_index <= `EAC_EX_SEL_MAX)
    else $error("reserved expander used");
endmodule // eac_access_regs_props
bind eac_access_regs eac_access_regs_props u_props (.clk, .rst,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .ee_start, .ee_op, .ee_addr, .ee_wdata,
  .ex_start, .ex_index, .ex_out_value, .ex_test_mode, .core_out_value,
  .ee_done, .ex_done, .irq);
`default_nettype wire

/* test/eac_far_model.sv */
// Behavioural EEPROM and expander sequencer model
`timescale 1ns/1ps
`default_nettype none
module eac_far_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  lat,
  input  wire logic        ee_start,
  input  wire logic        ee_op,
  input  wire logic [15:0] ee_addr,
  input  wire logic [7:0]  ee_wdata,
  output var  logic        ee_done,
  output var  logic [7:0]  ee_rdata,
  input  wire logic        ex_start,
  input  wire logic [3:0]  ex_index,
  output var  logic        ex_done,
  output var  logic [15:0] ex_in_value
);
  // ==========================================================
  // Sequencing
  logic [7:0] mem [0:255];
  logic [4:0] ecnt;
  logic [4:0] xcnt;
  always @(posedge clk) begin
    ee_done <= ecnt == 5'h01;
    ex_done <= xcnt == 5'h01;
    ee_rdata <= ~ee_rdata;
    ex_in_value <= ~ex_in_value;
    if (ecnt == 5'h01 && ee_op) ee_rdata <= mem[ee_addr[7:0]];
    if (ecnt == 5'h01 && !ee_op) mem[ee_addr[7:0]] <= ee_wdata;
    if (xcnt == 5'h01) ex_in_value <= {12'h5A0, ex_index};
    ecnt <= ee_start ? lat : ecnt - {4'h0, ecnt != 5'h00};
    xcnt <= ex_start ? lat : xcnt - {4'h0, xcnt != 5'h00};
    if (rst) begin
      ecnt <= 5'h00;
      xcnt <= 5'h00;
      ee_done <= 1'b0;
      ex_done <= 1'b0;
    end
  end
endmodule // eac_far_model
`default_nettype wire

/* test/eac_access_regs_test.sv */
// Self-checking bench for the access register bank
`timescale 1ns/1ps
`default_nettype none
`include "eac_defines.vh"
module eac_access_regs_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [15:0] core_out_value = 16'hBEEF;
  logic [4:0]  lat = 5'h01;
  logic [31:0] avs_readdata, d;
  logic [15:0] ee_addr, ex_out_value, ex_in_value;
  logic [7:0]  ee_wdata, ee_rdata;
  logic [3:0]  ex_index;
  logic        avs_waitrequest, ee_start, ee_op, ee_done, ex_start;
  logic        ex_test_mode, ex_done, irq;
  int          err_total = 0;
  int          total_checks = 0;
  always #4 clk = ~clk;
  eac_access_regs dut (.clk, .rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .ee_start, .ee_op, .ee_addr, .ee_wdata, .ee_done, .ee_rdata, .ex_start,
    .ex_index, .ex_out_value, .ex_test_mode, .ex_done, .ex_in_value,
    .core_out_value, .irq);
  eac_far_model far (.clk, .rst, .lat, .ee_start, .ee_op, .ee_addr,
    .ee_wdata, .ee_done, .ee_rdata, .ex_start, .ex_index, .ex_done,
    .ex_in_value);
  // ==========================================================
  // Tasks
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] v, input logic [3:0] be);
    avs_address <= a;
    avs_writedata <= v;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic wt(input logic [11:0] a, input int b);
    int n;
    d = 32'h0;
    for (n = 0; n < 40 && d[b] !== 1'b1; n++) acc(1'b0, a, 32'h0, 4'hF);
    chk({31'h0, d[b]}, 32'h1);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    acc(1'b0, 12'h42C, 32'h0, 4'hF);
    chk(d, `EAC_RESET_WORD);
    acc(1'b1, 12'h450, 32'hFFFFFFFF, 4'hF);
    acc(1'b0, 12'h450, 32'h0, 4'hF);
    chk(d, 32'h0);
    acc(1'b1, 12'h444, 32'h1, 4'hF);
    acc(1'b1, 12'h42C, 32'h005C0012, 4'hF);
    wt(12'h42C, 25);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, 12'h440, 32'h1, 4'hF);
    chk({31'h0, irq}, 32'h0);
    lat <= 5'h14;
    acc(1'b1, 12'h444, 32'h0, 4'hF);
    acc(1'b1, 12'h42C, 32'h04FF0012, 4'hF);
    acc(1'b0, 12'h42C, 32'h0, 4'hF);
    chk({31'h0, d[24]}, 32'h1);
    wt(12'h42C, 25);
    chk(d, 32'h065C0012);
    chk({31'h0, irq}, 32'h0);
    acc(1'b1, 12'h444, 32'h1, 4'hF);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, 12'h42C, 32'h02000000, 4'h8);
    chk({31'h0, irq}, 32'h0);
    chk({16'h0, ex_out_value}, 32'hBEEF);
    lat <= 5'h01;
    acc(1'b1, 12'h430, 32'h0000FFFF, 4'hF);
    acc(1'b0, 12'h430, 32'h0, 4'hF);
    chk(d, 32'h0);
    acc(1'b1, 12'h430, 32'h0D000000, 4'hF);
    wt(12'h430, 31);
    chk(d, 32'h8C005A03);
    acc(1'b1, 12'h430, 32'h8C000000, 4'hF);
    acc(1'b1, 12'h448, 32'h000000FF, 4'hF);
    acc(1'b1, 12'h430, 32'h0E000000, 4'hF);
    acc(1'b1, 12'h430, 32'h0E001234, 4'hF);
    chk({31'h0, ex_test_mode}, 32'h1);
    wt(12'h430, 31);
    chk(d, 32'h8E005A34);
    chk({24'h0, ex_out_value[7:0]}, 32'h34);
    acc(1'b1, 12'h430, 32'h2C000000, 4'hF);
    acc(1'b0, 12'h430, 32'h0, 4'hF);
    chk({28'h0, d[29:26]}, 32'h3);
    final_report();
  end
endmodule // eac_access_regs_test
`default_nettype wire
